// ==== design/sac_pkg.sv ====
package sac_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS        = 4000;
	localparam int STROBE_LOW_MAX_NS    = 6000;
	localparam int STROBE_LOW_MAX_CYC   = (STROBE_LOW_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int CONV_CYC_DEFAULT     = 1000;
	localparam int CAL_CYC_DEFAULT      = 80000;

	// ****************************************************************
	// Command byte layout
	// ****************************************************************
	localparam int CMD_BITS      = 8;
	localparam int BIT_START     = 7;
	localparam int BIT_POLARITY  = 6;
	localparam int BIT_CLKSRC    = 5;
	localparam int BIT_MODE_HI   = 4;
	localparam int BIT_MODE_LO   = 3;
	localparam int AUX_WIDTH     = 3;
	localparam int BITS_TO_START = 7;
	localparam int RESULT_BITS   = 16;
	localparam int SAMPLE_BITS   = 14;
	localparam logic [2:0] AUX_RESET = 3'h0;

	typedef enum logic [1:0] {
		SAC_MODE_SHORT = 2'h0,
		SAC_MODE_CAL   = 2'h1,
		SAC_MODE_PDOWN = 2'h2,
		SAC_MODE_LONG  = 2'h3
	} sac_mode_t;

	localparam int SHORT_CLKS = 24;
	localparam int LONG_CLKS  = 32;

	typedef struct packed {
		logic       polarity_select;
		logic       clock_source_select;
		sac_mode_t  mode;
		logic [2:0] aux;
	} sac_cmd_t;

	typedef struct packed {
		logic                    valid;
		logic                    unipolar;
		logic [SAMPLE_BITS-1:0]  sample;
	} sac_word_t;

	localparam logic [7:0] CMD_BYTE_RESET = 8'h20;

endpackage : sac_pkg

// ==== design/sac_buf2.sv ====
`timescale 1ns/1ps
module sac_buf2
	import sac_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	// ****************************************************************
	// Two-entry skid buffer
	// ****************************************************************
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic                  rd;
		logic                  wr;
		logic [1:0]            cnt;
	} sac_buf_state_t;

	sac_buf_state_t st, next_st;

	initial begin
		if (WIDTH < 1) $error("WIDTH must be positive");
	end

	assign in_ready  = (st.cnt != 2'h2);
	assign out_valid = (st.cnt != 2'h0);
	assign out_data  = st.mem[st.rd];

	always_comb begin
		logic push;
		logic pop;
		push    = in_valid && in_ready;
		pop     = out_valid && out_ready;
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr         = ~st.wr;
		end
		if (pop)
			next_st.rd = ~st.rd;
		if (push && !pop)
			next_st.cnt = st.cnt + 2'h1;
		else if (pop && !push)
			next_st.cnt = st.cnt - 2'h1;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

endmodule : sac_buf2

// ==== design/sac_core.sv ====
`timescale 1ns/1ps
module sac_core
	import sac_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYC_DEFAULT,
	parameter int CAL_CYC  = CAL_CYC_DEFAULT
) (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   sclk,
	input  wire logic                   cs_n,
	input  wire logic                   din,
	output logic                        dout,
	output logic                        dout_oe,
	output logic                        conversion_strobe,
	output logic                        conversion_strobe_oe,
	output logic                        aux_out_two,
	output logic                        aux_out_one,
	output logic                        aux_out_zero,
	output logic                        power_down,
	input  wire logic                   sample_valid,
	output logic                        sample_ready,
	input  wire logic [SAMPLE_BITS-1:0] sample_data,
	output logic                        sample_request,
	output logic                        calibrate_busy
);

	initial begin
		if (CONV_CYC < 1 || CONV_CYC > STROBE_LOW_MAX_CYC)
			$error("CONV_CYC must fit the strobe low limit");
		if (CAL_CYC < 1)
			$error("CAL_CYC must be positive");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_HUNT,
		ST_CMD,
		ST_EXT_CONV,
		ST_INT_CONV,
		ST_CAL,
		ST_DONE
	} sac_phase_t;

	typedef struct packed {
		logic [1:0]             sclk_sync;
		logic [1:0]             cs_sync;
		logic [1:0]             din_sync;
		logic                   sclk_q;
		logic                   cs_q;
		sac_phase_t             phase;
		logic [2:0]             bit_cnt;
		logic [6:0]             shift;
		sac_cmd_t               cmd;
		logic [5:0]             clk_cnt;
		logic [16:0]            timer;
		logic [RESULT_BITS-1:0] out_sr;
		logic [RESULT_BITS-1:0] store;
		logic                   dout;
		logic                   strobe;
		logic [2:0]             aux;
		logic                   pdown;
		logic                   req;
	} sac_state_t;

	sac_state_t st, next_st;

	logic                   buf_valid;
	logic [SAMPLE_BITS:0]   buf_data;
	logic                   buf_take;

	// Converter samples pass a two-entry buffer so a stall keeps them
	sac_buf2 #(
		.WIDTH (SAMPLE_BITS + 1)
	) u_buf (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.in_data   ({st.cmd.polarity_select, sample_data}),
		.out_valid (buf_valid),
		.out_ready (buf_take),
		.out_data  (buf_data)
	);

	function automatic logic [RESULT_BITS-1:0] fmt_result(input logic [SAMPLE_BITS:0] w);
		logic [SAMPLE_BITS-1:0] s;
		s = w[SAMPLE_BITS-1:0];
		// Left-justified; bipolar keeps sign in the MSB
		if (w[SAMPLE_BITS])
			fmt_result = {s, 2'h0};
		else
			fmt_result = {s ^ {1'b1, {(SAMPLE_BITS-1){1'b0}}}, 2'h0};
	endfunction : fmt_result

	function automatic logic [5:0] conv_clks(input sac_mode_t m);
		conv_clks = (m == SAC_MODE_LONG) ? 6'(LONG_CLKS) : 6'(SHORT_CLKS);
	endfunction : conv_clks

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic     sclk_rise;
		logic     sclk_fall;
		logic     cs_low;
		logic     cs_fell;
		logic     din_s;
		logic     start_ok;
		logic     last_bit;
		sac_cmd_t newcmd;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		cs_low    = 1'b0;
		cs_fell   = 1'b0;
		din_s     = 1'b0;
		start_ok  = 1'b0;
		newcmd    = '0;
		last_bit  = 1'b0;
		buf_take  = 1'b0;
		next_st   = st;

		next_st.sclk_sync = {st.sclk_sync[0], sclk};
		next_st.cs_sync   = {st.cs_sync[0], cs_n};
		next_st.din_sync  = {st.din_sync[0], din};
		next_st.sclk_q    = st.sclk_sync[1];
		next_st.cs_q      = st.cs_sync[1];
		cs_low    = !st.cs_sync[1];
		// Serial port disabled while deselected
		sclk_rise = cs_low && st.sclk_sync[1] && !st.sclk_q;
		sclk_fall = cs_low && !st.sclk_sync[1] && st.sclk_q;
		cs_fell   = cs_low && st.cs_q;
		din_s     = st.din_sync[1];
		next_st.req = 1'b0;

		// Start bit allowed when idle, or after a deselect pulse unless a command is being shifted in
		start_ok = (st.phase == ST_HUNT) || (st.phase == ST_DONE);
		// A finished result stays readable across a deselect pulse
		if (cs_fell && st.phase != ST_CMD && st.phase != ST_DONE) begin
			next_st.phase   = ST_HUNT;
			next_st.bit_cnt = '0;
		end
		// Last command bit arrives after the conversion has already begun
		last_bit = sclk_rise && !cs_fell && st.phase != ST_CMD
			&& st.bit_cnt == 3'(CMD_BITS - 1);

		if (sclk_rise && din_s && !last_bit && (start_ok || next_st.phase == ST_HUNT)) begin
			next_st.phase   = ST_CMD;
			next_st.bit_cnt = 3'h1;
			next_st.shift   = '0;
		end else if (sclk_rise && st.phase == ST_CMD) begin
			next_st.shift   = {st.shift[5:0], din_s};
			next_st.bit_cnt = st.bit_cnt + 3'h1;
		end

		if (st.phase == ST_CMD && st.bit_cnt == 3'(BITS_TO_START) && sclk_fall) begin
			newcmd = sac_cmd_t'({st.shift[5:0], din_s});
			// Last bit not yet sampled on this edge; keep previous LSB for now
			newcmd = sac_cmd_t'({st.shift[5:0], st.aux[0]});
			next_st.cmd   = newcmd;
			next_st.pdown = 1'b0;
			next_st.clk_cnt = '0;
			case (newcmd.mode)
				SAC_MODE_PDOWN: begin
					next_st.pdown = 1'b1;
					next_st.phase = ST_DONE;
				end
				SAC_MODE_CAL: begin
					next_st.phase  = ST_CAL;
					next_st.timer  = 17'(CAL_CYC);
					next_st.strobe = !newcmd.clock_source_select;
				end
				default: begin
					next_st.req = 1'b1;
					if (newcmd.clock_source_select) begin
						next_st.phase  = ST_INT_CONV;
						next_st.timer  = 17'(CONV_CYC);
						next_st.strobe = 1'b0;
					end else begin
						next_st.phase  = ST_EXT_CONV;
						next_st.strobe = 1'b0;
					end
				end
			endcase
		end

		// Port register loads all three bits on the last command bit
		if (last_bit) begin
			next_st.aux     = {st.shift[1:0], din_s};
			next_st.cmd.aux = {st.shift[1:0], din_s};
			next_st.bit_cnt = '0;
		end

		case (st.phase)
			ST_EXT_CONV: begin
				if (sclk_fall) begin
					next_st.clk_cnt = st.clk_cnt + 6'h1;
					next_st.strobe  = (st.clk_cnt == '0);
					if (st.clk_cnt == 6'h0) begin
						buf_take       = 1'b1;
						next_st.out_sr = fmt_result({st.cmd.polarity_select,
							buf_data[SAMPLE_BITS-1:0]});
						next_st.dout   = next_st.out_sr[RESULT_BITS-1];
					end else begin
						next_st.out_sr = {st.out_sr[RESULT_BITS-2:0], 1'b0};
						next_st.dout   = st.out_sr[RESULT_BITS-2];
					end
					if (st.clk_cnt == conv_clks(st.cmd.mode) - 6'h8)
						next_st.phase = ST_DONE;
				end
			end
			ST_INT_CONV: begin
				// Runs on its own while deselected; a chip select falling edge aborts it
				if (st.timer <= 17'h1 && buf_valid) begin
					buf_take       = 1'b1;
					next_st.store  = fmt_result({st.cmd.polarity_select,
						buf_data[SAMPLE_BITS-1:0]});
					next_st.out_sr = next_st.store;
					next_st.dout   = next_st.store[RESULT_BITS-1];
					next_st.strobe = 1'b1;
					next_st.phase  = ST_DONE;
				end else if (st.timer > 17'h1)
					next_st.timer = st.timer - 17'h1;
			end
			ST_CAL: begin
				if (st.timer == 17'h1) begin
					next_st.strobe = st.cmd.clock_source_select;
					next_st.phase  = ST_DONE;
				end else
					next_st.timer = st.timer - 17'h1;
			end
			ST_DONE: begin
				if (sclk_fall && st.cmd.clock_source_select) begin
					next_st.out_sr = {st.out_sr[RESULT_BITS-2:0], 1'b0};
					next_st.dout   = st.out_sr[RESULT_BITS-2];
				end
			end
			default: ;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st           <= '0;
			st.sclk_q    <= 1'b0;
			st.cs_q      <= 1'b1;
			st.cs_sync   <= 2'h3;
			st.cmd       <= sac_cmd_t'(CMD_BYTE_RESET[6:0]);
			st.aux       <= AUX_RESET;
			st.strobe    <= 1'b1;
		end else
			st <= next_st;
	end

	// ****************************************************************
	// Pins
	// ****************************************************************
	assign dout                 = st.dout;
	assign dout_oe              = !st.cs_sync[1];
	assign conversion_strobe    = st.strobe;
	// Internal mode keeps driving so the host can poll it deselected
	assign conversion_strobe_oe = st.cmd.clock_source_select || !st.cs_sync[1];
	assign aux_out_two          = st.aux[2];
	assign aux_out_one          = st.aux[1];
	assign aux_out_zero         = st.aux[0];
	assign power_down           = st.pdown;
	assign sample_request       = st.req;
	assign calibrate_busy       = (st.phase == ST_CAL);

endmodule : sac_core

// ==== testbench/sac_core_assertions.sv ====
`timescale 1ns/1ps
module sac_chk
	import sac_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYC_DEFAULT,
	parameter int CAL_CYC  = CAL_CYC_DEFAULT
) (
	input wire logic                   clk,
	input wire logic                   sys_rst,
	input wire logic                   sclk,
	input wire logic                   cs_n,
	input wire logic                   din,
	input wire logic                   dout,
	input wire logic                   dout_oe,
	input wire logic                   conversion_strobe,
	input wire logic                   conversion_strobe_oe,
	input wire logic                   aux_out_two,
	input wire logic                   aux_out_one,
	input wire logic                   aux_out_zero,
	input wire logic                   power_down,
	input wire logic                   sample_valid,
	input wire logic                   sample_ready,
	input wire logic [SAMPLE_BITS-1:0] sample_data,
	input wire logic                   sample_request,
	input wire logic                   calibrate_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ****************************************************************
	// Strobe low time, conversions only
	// ****************************************************************
	logic [11:0] low_cnt;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_cnt <= 12'h0;
		end else if (conversion_strobe || calibrate_busy || power_down) begin
			low_cnt <= 12'h0;
		end else if (low_cnt != 12'hfff) begin
			low_cnt <= low_cnt + 12'h1;
		end
	end

	chk_strobe_low_max: assert property (low_cnt <= STROBE_LOW_MAX_CYC)
		else $error("strobe low too long");
	chk_dout_float: assert property (cs_n [*4] |-> !dout_oe)
		else $error("dout driven while deselected");
	chk_dout_drive: assert property (!cs_n [*4] |-> dout_oe)
		else $error("dout not driven while selected");
	chk_strobe_oe_sel: assert property (!cs_n [*4] |-> conversion_strobe_oe)
		else $error("strobe floats while selected");
	chk_strobe_float_cs: assert property ($fell(conversion_strobe_oe) |-> cs_n)
		else $error("strobe released with chip select low");
	chk_req_single: assert property (sample_request |=> !sample_request)
		else $error("start pulse longer than one cycle");
	chk_req_on_fall: assert property (sample_request |-> !sclk && !cs_n)
		else $error("start outside a falling shift edge");
	chk_aux_idle_hold: assert property (cs_n [*6] |=> $stable({aux_out_two, aux_out_one, aux_out_zero}))
		else $error("aux changed while deselected");
	chk_dout_on_fall: assert property (dout_oe && $changed(dout) |-> !sclk)
		else $error("dout changed with shift clock high");
	chk_reset_clear: assert property (disable iff (1'b0) sys_rst |->
		{aux_out_two, aux_out_one, aux_out_zero} == 3'h0 && !power_down && conversion_strobe)
		else $error("reset values wrong");
endmodule : sac_chk

bind sac_core sac_chk #(.CONV_CYC(CONV_CYC), .CAL_CYC(CAL_CYC)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
	.dout_oe(dout_oe), .conversion_strobe(conversion_strobe),
	.conversion_strobe_oe(conversion_strobe_oe), .aux_out_two(aux_out_two),
	.aux_out_one(aux_out_one), .aux_out_zero(aux_out_zero), .power_down(power_down),
	.sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
	.sample_request(sample_request), .calibrate_busy(calibrate_busy)
);

// ==== testbench/sac_host_model.sv ====
`timescale 1ns/1ps
module sac_host_model (
	output logic     sclk,
	output logic     cs_n,
	output logic     din,
	input wire logic dout,
	input wire logic dout_oe
);
	// Commands slower than reads: command rate limit is lower
	localparam realtime HALF_CMD = 105.0;
	localparam realtime HALF_RD  = 62.5;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din  = 1'b0;
	end
	// Deselected data line wanders so stale bits are never trusted
	always #(HALF_CMD) din = cs_n ? ~din : din;

	task automatic select();
		cs_n = 1'b0;
		#(HALF_CMD);
	endtask : select
	task automatic release_bus();
		cs_n = 1'b1;
		#(HALF_CMD);
	endtask : release_bus
	task automatic bit_out(input logic b);
		din = b;
		#(HALF_CMD) sclk = 1'b1;
		#(HALF_CMD) sclk = 1'b0;
	endtask : bit_out
	task automatic send_cmd(input logic [7:0] c, input int zeros);
		if (cs_n) begin
			select();
		end
		repeat (zeros) bit_out(1'b0);
		for (int i = 7; i >= 0; i--) begin
			bit_out(c[i]);
		end
	endtask : send_cmd
	task automatic stray(input int n);
		repeat (n) begin
			#(HALF_RD) sclk = 1'b1;
			#(HALF_RD) sclk = 1'b0;
		end
	endtask : stray
	task automatic read_word(output logic [15:0] w);
		din = 1'b0;
		w = '0;
		// Each bit is taken just before the next rise, once it has settled
		for (int i = 0; i < 16; i++) begin
			#(HALF_RD) w = {w[14:0], dout};
			if (i < 15) begin
				sclk = 1'b1;
				#(HALF_RD) sclk = 1'b0;
			end
		end
	endtask : read_word
endmodule : sac_host_model

// ==== testbench/tb_serial_adc_command_interface.sv ====
`timescale 1ns/1ps
module tb_serial_adc_command_interface
	import sac_pkg::*;
;
	logic                   clk;
	logic                   sys_rst;
	logic                   sample_valid;
	logic [SAMPLE_BITS-1:0] sample_data;
	wire logic              sclk, cs_n, din, dout, dout_oe, conversion_strobe;
	wire logic              conversion_strobe_oe, aux_out_two, aux_out_one, aux_out_zero;
	wire logic              power_down, sample_ready, sample_request, calibrate_busy;
	int                     bad_count;
	int                     checks_done;
	int                     req_cnt;
	int                     cycles;
	int                     rc;
	logic [31:0]            seed;
	logic [15:0]            w;
	logic [SAMPLE_BITS-1:0] to_send[$];
	logic [SAMPLE_BITS-1:0] in_buf[$];

	initial clk = 1'b0;
	always #2 clk = ~clk;

	sac_core #(.CONV_CYC(800), .CAL_CYC(400)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe), .conversion_strobe(conversion_strobe),
		.conversion_strobe_oe(conversion_strobe_oe), .aux_out_two(aux_out_two),
		.aux_out_one(aux_out_one), .aux_out_zero(aux_out_zero), .power_down(power_down),
		.sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
		.sample_request(sample_request), .calibrate_busy(calibrate_busy)
	);
	sac_host_model i_host (
		.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Samples arrive offset binary; bipolar results are two's complement
	function automatic logic [15:0] exp_result(input logic [13:0] s, input logic uni);
		return uni ? {s, 2'b00} : {s ^ 14'h2000, 2'b00};
	endfunction : exp_result

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic cmp_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp_bit
	task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_word
	task automatic wait_strobe();
		for (int n = 0; n < 3000 && conversion_strobe !== 1'b1; n++) @(negedge clk);
		cmp_bit("strobe_high", 1'b1, conversion_strobe);
		repeat (4) @(negedge clk);
	endtask : wait_strobe

	// ****************************************************************
	// Sample stream into the two-entry buffer
	// ****************************************************************
	always @(negedge clk) begin
		sample_valid <= (to_send.size() != 0);
		sample_data <= (to_send.size() != 0) ? to_send[0] : sample_data;
	end
	always @(posedge clk) begin
		cycles++;
		req_cnt += (sample_request === 1'b1) ? 1 : 0;
		if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
			in_buf.push_back(sample_data);
			void'(to_send.pop_front());
		end
		if (cycles == 60000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic run_cmd(input logic [7:0] c);
		seed = lfsr(seed);
		to_send.push_back(seed[SAMPLE_BITS-1:0]);
		i_host.send_cmd(c, int'(seed[17:16]));
		repeat (8) @(negedge clk);
		cmp_word("aux", {13'h0, c[2:0]}, {13'h0, aux_out_two, aux_out_one, aux_out_zero});
		cmp_bit("power_down", c[4:3] == SAC_MODE_PDOWN, power_down);
		cmp_bit("cal_busy", c[4:3] == SAC_MODE_CAL, calibrate_busy);
		if (c[4:3] == SAC_MODE_PDOWN) begin
			repeat (100) @(negedge clk);
			cmp_word("aux_held", {13'h0, c[2:0]}, {13'h0, aux_out_two, aux_out_one, aux_out_zero});
		end else begin
			cmp_bit("strobe_low", 1'b0, conversion_strobe);
			if (c[6]) begin
				i_host.release_bus();
			end
			wait_strobe();
			cmp_bit("strobe_oe", 1'b1, conversion_strobe_oe);
			i_host.select();
			if (c[4:3] != SAC_MODE_CAL) begin
				i_host.read_word(w);
				cmp_word("result", exp_result(in_buf.pop_front(), c[6]), w);
			end
		end
		i_host.release_bus();
		repeat (8) @(negedge clk);
		cmp_bit("dout_oe", 1'b0, dout_oe);
	endtask : run_cmd

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		sys_rst = 1'b1;
		sample_valid = 1'b0;
		sample_data = '0;
		seed = 32'h7ebe;
		bad_count = 0;
		checks_done = 0;
		req_cnt = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		cmp_bit("strobe_rst", 1'b1, conversion_strobe);
		cmp_word("aux_rst", 16'h0, {13'h0, aux_out_two, aux_out_one, aux_out_zero});
		repeat (3) begin
			seed = lfsr(seed);
			to_send.push_back(seed[SAMPLE_BITS-1:0]);
		end
		repeat (40) @(negedge clk);
		cmp_bit("buf_full", 1'b0, sample_ready);
		cmp_word("buf_fill", 16'h2, 16'(in_buf.size()));
		i_host.select();
		i_host.release_bus();
		i_host.stray(8);
		cmp_word("no_start", 16'h0, 16'(req_cnt));
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 2; k++) begin
				seed = lfsr(seed);
				run_cmd({1'b1, k[0], 1'b1, m[1:0], seed[2:0]});
			end
		end
		rc = req_cnt;
		i_host.send_cmd(8'hb9, 0);
		i_host.release_bus();
		i_host.send_cmd(8'he6, 1);
		repeat (8) @(negedge clk);
		cmp_word("abort_req", 16'(rc + 2), 16'(req_cnt));
		cmp_word("abort_aux", 16'h6, {13'h0, aux_out_two, aux_out_one, aux_out_zero});
		wait_strobe();
		i_host.read_word(w);
		cmp_word("abort_result", exp_result(in_buf.pop_front(), 1'b1), w);
		i_host.release_bus();
		i_host.send_cmd(8'h81, 1);
		i_host.read_word(w);
		cmp_word("ext_result", exp_result(in_buf.pop_front(), 1'b0), w);
		i_host.release_bus();
		i_host.send_cmd(8'h95, 2);
		i_host.release_bus();
		repeat (8) @(negedge clk);
		cmp_bit("ext_strobe_oe", 1'b0, conversion_strobe_oe);
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		cmp_word("aux_mid_rst", 16'h0, {13'h0, aux_out_two, aux_out_one, aux_out_zero});
		sys_rst = 1'b0;
		in_buf.delete();
		repeat (10) @(negedge clk);
		wrap_up();
	end
endmodule : tb_serial_adc_command_interface
